/* File: hw/cpd_limit_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_limit_decode (
  input wire logic sel_low_i,
  input wire logic sel_high_i,
  input wire logic lim_pin_short_i,
  input wire logic floor_pin_short_i,
  output var cpd_pkg::cpd_lim_t lim_o,
  output var cpd_pkg::cpd_floor_t floor_o
);
  always_comb begin
    unique case ({sel_high_i, sel_low_i})
      2'b00: begin
        lim_o = cpd_pkg::CPD_LIM_500;
        floor_o = cpd_pkg::CPD_FLOOR_436;
      end
      2'b10: begin
        lim_o = cpd_pkg::CPD_LIM_100;
        floor_o = cpd_pkg::CPD_FLOOR_436;
      end
      2'b01: begin
        lim_o = lim_pin_short_i ? cpd_pkg::CPD_LIM_2000 : cpd_pkg::CPD_LIM_EXT;
        floor_o = floor_pin_short_i ? cpd_pkg::CPD_FLOOR_436 : cpd_pkg::CPD_FLOOR_EXT;
      end
      default: begin
        lim_o = cpd_pkg::CPD_LIM_HIZ;
        floor_o = cpd_pkg::CPD_FLOOR_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: hw/cpd_pkg.sv */
package cpd_pkg;

  // ----------------------------------------------------------------
  // Register map (word-indexed plain port)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_DPLUS = 8'h07;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_HOSTCFG = 8'h11;
  localparam int FORCE_DET_BIT = 4;
  localparam int CLR_DP_BIT = 4;
  localparam int WDOG_EN_BIT = 0;
  localparam int WDOG_KICK_BIT = 1;

  // ----------------------------------------------------------------
  // Input limit and timer codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPD_LIM_100 = 3'h0,
    CPD_LIM_500 = 3'h1,
    CPD_LIM_1500 = 3'h2,
    CPD_LIM_2000 = 3'h3,
    CPD_LIM_EXT = 3'h4,
    CPD_LIM_HIZ = 3'h5
  } cpd_lim_t;

  typedef enum logic [1:0] {
    CPD_FLOOR_436 = 2'h0,
    CPD_FLOOR_EXT = 2'h1,
    CPD_FLOOR_NONE = 2'h2
  } cpd_floor_t;

  typedef enum logic [1:0] {
    CPD_TMR_6H = 2'h0,
    CPD_TMR_45M = 2'h1,
    CPD_TMR_NONE = 2'h2
  } cpd_tmr_t;

  typedef enum logic [2:0] {
    CPD_PORT_NONE = 3'h0,
    CPD_PORT_DCP = 3'h1,
    CPD_PORT_CDP = 3'h2,
    CPD_PORT_SDP = 3'h3,
    CPD_PORT_NSTD = 3'h4
  } cpd_port_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int WDOG_MS = 50;
  localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
  localparam int DCD_US = 600;
  localparam int DCD_CYC = DCD_US * CLK_MHZ;

endpackage

/* File: hw/cpd_top.sv */
// What this block does
// - Both selects low: 500mA, 4.36V floor; high select alone: 100mA, 4.36V.
// - Low select alone: external limit and floor; both high: Hi-Z, no floor.
// - A select change updates floor in every mode; limit follows it only outside host mode.
// - Detection first at power up; selects ignored until later pin change.
// - Power-good stays released until detection completes.
// - Valid supply: any register write gives host mode, else default mode.
// - Stand-alone mode takes the input limit from the select pins.
// - Enabled watchdog expiry leaves host mode and restores defaults.
// - Shorted pins with low select alone: limit 2A, floor 4.36V; shorted charge-current pin flags a fault.
// - Detection runs only in stand-alone mode unless forced.
// - Force-detect bit runs detection on the next insertion.
// - Accessory adapters not identified; such ports get 500mA.
// - Detector has five states plus idle and done.
// - Enter contact detect on VBUS insertion when not host or forced.
// - Contact timer expiry goes to non-standard test, else primary.
// - Primary splits DCP/CDP from SDP/non-standard.
// - Non-standard pass goes to configuration, fail back to primary.
// - Secondary resolves the pair, then configuration.
// - DCP: external limit, 6h; non-standard: 500mA, 6h.
// - CDP/SDP dead battery: 100mA 45min; CDP good 1500mA 6h; SDP good Hi-Z.
// - D+ source on during wakeup; cleared by clear-source bit once good.
`timescale 1ns/1ps
`default_nettype none
module cpd_top #(
  parameter int WDOG_CYCLES = cpd_pkg::WDOG_CYC,
  parameter int DCD_CYCLES = cpd_pkg::DCD_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic limit_select_low_i,
  input wire logic limit_select_high_i,
  input wire logic supply_good_i,
  input wire logic vbus_present_i,
  input wire logic battery_good_i,
  input wire logic lim_pin_short_i,
  input wire logic floor_pin_short_i,
  input wire logic chg_pin_short_i,
  input wire logic contact_ok_i,
  input wire logic primary_dcp_cdp_i,
  input wire logic secondary_hi_i,
  input wire logic nstd_pass_i,
  input wire logic [2:0] host_lim_i,
  output var cpd_pkg::cpd_lim_t input_limit_o,
  output var cpd_pkg::cpd_floor_t input_voltage_floor_o,
  output var cpd_pkg::cpd_tmr_t charge_timer_o,
  output logic charge_fault_o,
  output logic host_mode_o,
  output logic dplus_src_o,
  output logic power_good_oe_o,
  output logic power_good_out_o
);

  // ----------------------------------------------------------------
  // Detector states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPD_IDLE,
    CPD_DCD,
    CPD_PRI,
    CPD_SEC,
    CPD_NSTD,
    CPD_CFG,
    CPD_DONE
  } cpd_det_t;

  cpd_det_t det_r;
  logic host_r;
  logic force_r;
  logic wdog_en_r;
  logic [31:0] wdog_cnt_r;
  logic [31:0] dcd_cnt_r;
  logic pri_dcp_r;
  cpd_pkg::cpd_port_t port_r;
  logic det_done_r;
  logic vbus_q_r;
  logic [1:0] sel_q_r;
  logic pins_live_r;
  logic dsrc_r;
  logic wr_ctrl;
  logic wr_dplus;
  logic wr_cfg;
  logic vbus_rise;
  logic sel_chg;
  cpd_pkg::cpd_lim_t pin_lim;
  cpd_pkg::cpd_floor_t pin_floor;

  assign wr_ctrl = reg_wr_i && reg_addr_i == cpd_pkg::REG_CTRL;
  assign wr_dplus = reg_wr_i && reg_addr_i == cpd_pkg::REG_DPLUS;
  assign wr_cfg = reg_wr_i && reg_addr_i == cpd_pkg::REG_HOSTCFG;
  assign vbus_rise = vbus_present_i && !vbus_q_r;
  assign sel_chg = {limit_select_high_i, limit_select_low_i} != sel_q_r;

  cpd_limit_decode u_dec (
    .sel_low_i(limit_select_low_i),
    .sel_high_i(limit_select_high_i),
    .lim_pin_short_i(lim_pin_short_i),
    .floor_pin_short_i(floor_pin_short_i),
    .lim_o(pin_lim),
    .floor_o(pin_floor)
  );

  // ----------------------------------------------------------------
  // Host mode and watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      host_r <= 1'b0;
      wdog_en_r <= 1'b0;
      wdog_cnt_r <= 32'h0;
    end else if (clk_en_i) begin
      if (!supply_good_i) begin
        host_r <= 1'b0;
      end else if (reg_wr_i) begin
        host_r <= 1'b1;
        wdog_cnt_r <= 32'h0;
        if (wr_cfg) begin
          wdog_en_r <= reg_wdata_i[cpd_pkg::WDOG_EN_BIT];
        end
      end else if (host_r && wdog_en_r) begin
        if (wdog_cnt_r >= 32'(WDOG_CYCLES - 1)) begin
          host_r <= 1'b0;
          wdog_cnt_r <= 32'h0;
        end else begin
          wdog_cnt_r <= wdog_cnt_r + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Force-detect bit: set by host, consumed at detection entry
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      force_r <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_ctrl && reg_wdata_i[cpd_pkg::FORCE_DET_BIT]) begin
        force_r <= 1'b1;
      end else if (det_r == CPD_IDLE && vbus_rise) begin
        force_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port detection state machine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      det_r <= CPD_IDLE;
      dcd_cnt_r <= 32'h0;
      pri_dcp_r <= 1'b0;
      port_r <= cpd_pkg::CPD_PORT_NONE;
      det_done_r <= 1'b0;
      vbus_q_r <= 1'b0;
    end else if (clk_en_i) begin
      vbus_q_r <= vbus_present_i;
      if (!vbus_present_i) begin
        det_r <= CPD_IDLE;
        det_done_r <= 1'b0;
        port_r <= cpd_pkg::CPD_PORT_NONE;
      end else begin
        unique case (det_r)
          CPD_IDLE: begin
            if (vbus_rise && (!host_r || force_r)) begin
              det_r <= CPD_DCD;
              dcd_cnt_r <= 32'h0;
            end
          end
          CPD_DCD: begin
            if (contact_ok_i) begin
              det_r <= CPD_PRI;
            end else if (dcd_cnt_r >= 32'(DCD_CYCLES - 1)) begin
              det_r <= CPD_NSTD;
            end else begin
              dcd_cnt_r <= dcd_cnt_r + 32'h1;
            end
          end
          CPD_PRI: begin
            pri_dcp_r <= primary_dcp_cdp_i;
            det_r <= CPD_SEC;
          end
          CPD_SEC: begin
            if (pri_dcp_r) begin
              port_r <= secondary_hi_i ? cpd_pkg::CPD_PORT_DCP : cpd_pkg::CPD_PORT_CDP;
            end else begin
              port_r <= secondary_hi_i ? cpd_pkg::CPD_PORT_NSTD : cpd_pkg::CPD_PORT_SDP;
            end
            det_r <= CPD_CFG;
          end
          CPD_NSTD: begin
            if (nstd_pass_i) begin
              port_r <= cpd_pkg::CPD_PORT_NSTD;
              det_r <= CPD_CFG;
            end else begin
              det_r <= CPD_PRI;
            end
          end
          CPD_CFG: begin
            det_done_r <= 1'b1;
            det_r <= CPD_DONE;
          end
          CPD_DONE: begin
            det_r <= CPD_DONE;
          end
          default: begin
            det_r <= CPD_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Select pins gated until a change after detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sel_q_r <= 2'h0;
      pins_live_r <= 1'b0;
    end else if (clk_en_i) begin
      sel_q_r <= {limit_select_high_i, limit_select_low_i};
      if (!det_done_r || !vbus_present_i) begin
        pins_live_r <= 1'b0;
      end else if (sel_chg) begin
        pins_live_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // D+ source during wakeup
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dsrc_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!vbus_present_i) begin
        dsrc_r <= 1'b0;
      end else if (det_r == CPD_CFG && !battery_good_i &&
                   (port_r == cpd_pkg::CPD_PORT_CDP || port_r == cpd_pkg::CPD_PORT_SDP)) begin
        dsrc_r <= 1'b1;
      end else if (wr_dplus && reg_wdata_i[cpd_pkg::CLR_DP_BIT] && battery_good_i) begin
        dsrc_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit, floor and timer selection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      input_limit_o <= cpd_pkg::CPD_LIM_100;
      input_voltage_floor_o <= cpd_pkg::CPD_FLOOR_436;
      charge_timer_o <= cpd_pkg::CPD_TMR_6H;
    end else if (clk_en_i) begin
      input_voltage_floor_o <= pin_floor;
      charge_timer_o <= cpd_pkg::CPD_TMR_6H;
      if (host_r) begin
        input_limit_o <= cpd_pkg::cpd_lim_t'(host_lim_i);
      end else if (pins_live_r || (!det_done_r && det_r == CPD_IDLE)) begin
        input_limit_o <= pin_lim;
      end else begin
        unique case (port_r)
          cpd_pkg::CPD_PORT_DCP: begin
            input_limit_o <= cpd_pkg::CPD_LIM_EXT;
          end
          cpd_pkg::CPD_PORT_CDP: begin
            input_limit_o <= battery_good_i ? cpd_pkg::CPD_LIM_1500 : cpd_pkg::CPD_LIM_100;
            charge_timer_o <= battery_good_i ? cpd_pkg::CPD_TMR_6H : cpd_pkg::CPD_TMR_45M;
          end
          cpd_pkg::CPD_PORT_SDP: begin
            input_limit_o <= battery_good_i ? cpd_pkg::CPD_LIM_HIZ : cpd_pkg::CPD_LIM_100;
            charge_timer_o <= battery_good_i ? cpd_pkg::CPD_TMR_NONE : cpd_pkg::CPD_TMR_45M;
          end
          default: begin
            input_limit_o <= cpd_pkg::CPD_LIM_500;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      charge_fault_o <= 1'b0;
      host_mode_o <= 1'b0;
      dplus_src_o <= 1'b0;
      power_good_oe_o <= 1'b0;
      power_good_out_o <= 1'b0;
    end else if (clk_en_i) begin
      charge_fault_o <= chg_pin_short_i;
      host_mode_o <= host_r;
      dplus_src_o <= dsrc_r;
      power_good_oe_o <= supply_good_i && det_done_r;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          cpd_pkg::REG_CTRL: reg_rdata_o <= 8'(force_r) << cpd_pkg::FORCE_DET_BIT;
          cpd_pkg::REG_DPLUS: reg_rdata_o <= 8'(dsrc_r) << cpd_pkg::CLR_DP_BIT;
          cpd_pkg::REG_STATUS: reg_rdata_o <= {det_done_r, pins_live_r, host_r, 2'h0, port_r};
          cpd_pkg::REG_HOSTCFG: reg_rdata_o <= {7'h00, wdog_en_r};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  pg_after_det_a: assert property (power_good_oe_o |-> $past(det_done_r))
    else $error("power good driven before detection done");
  det_entry_a: assert property ($rose(vbus_present_i) && det_r == CPD_IDLE && !host_r && clk_en_i
                                |=> det_r == CPD_DCD)
    else $error("detection not entered");
  host_blocks_a: assert property (det_r == CPD_IDLE && host_r && !force_r && clk_en_i
                                  && vbus_present_i |=> det_r != CPD_DCD)
    else $error("detection ran in host mode");
  nstd_fail_a: assert property (det_r == CPD_NSTD && !nstd_pass_i && vbus_present_i && clk_en_i
                                |=> det_r == CPD_PRI)
    else $error("non-standard fail not back to primary");
  sec_to_cfg_a: assert property (det_r == CPD_SEC && vbus_present_i && clk_en_i
                                 |=> det_r == CPD_CFG)
    else $error("secondary did not reach configuration");
  fault_follow_a: assert property (clk_en_i && chg_pin_short_i |=> charge_fault_o)
    else $error("shorted charge pin without fault");
  floor_none_a: assert property (clk_en_i && limit_select_low_i && limit_select_high_i
                                 |=> input_voltage_floor_o == cpd_pkg::CPD_FLOOR_NONE)
    else $error("floor not removed for hi-z");
  pins_gate_a: assert property (!det_done_r |-> !pins_live_r)
    else $error("pins live before detection done");
  wdog_exit_a: assert property (host_r && wdog_en_r && !reg_wr_i && clk_en_i
                                && wdog_cnt_r >= 32'(WDOG_CYCLES - 1) |=> !host_r)
    else $error("watchdog expiry kept host mode");
  sequence det_pri_s;
    det_r == CPD_PRI && vbus_present_i && clk_en_i;
  endsequence
  pri_to_sec_a: assert property (det_pri_s |=> det_r == CPD_SEC)
    else $error("primary did not reach secondary");

endmodule
`default_nettype wire

/* File: tb/cpd_usb_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// USB port or adapter seen on the data lines
// ----------------------------------------------------------------
// Kind: 1 DCP, 2 CDP, 3 SDP, 4 non-standard, 5 proprietary (no
// contact, passes), 6 no contact, fails proprietary test, then DCP
module cpd_usb_port_model (
  input wire logic mclk_i,
  input wire logic attach_i,
  input wire logic [2:0] kind_i,
  input wire logic slow_i,
  output logic vbus_o,
  output logic contact_o,
  output logic primary_o,
  output logic secondary_o,
  output logic nstd_o
);
  logic [3:0] age_r;
  logic [2:0] churn_r = 3'h5;

  always_ff @(posedge mclk_i) begin
    if (!attach_i) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
    churn_r <= churn_r + 3'h3;
  end

  always_comb begin
    vbus_o = attach_i;
    // A slow port makes contact only after nine cycles
    contact_o = attach_i && (kind_i < 3'h5) && (!slow_i || (age_r > 4'h8));
    if (!attach_i) begin
      // Released lines carry no stable level
      {primary_o, secondary_o, nstd_o} = churn_r;
    end else begin
      primary_o = (kind_i == 3'h1) || (kind_i == 3'h2) || (kind_i == 3'h6);
      secondary_o = (kind_i == 3'h1) || (kind_i == 3'h4) || (kind_i == 3'h6);
      nstd_o = (kind_i == 3'h5);
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_charger_port_detect_input_limit_resistor_pin_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_charger_port_detect_input_limit_resistor_pin_select;
  localparam int WDOG = 60;
  localparam int DCD = 20;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b1;
  logic batt = 1'b1;
  logic sup = 1'b1;
  logic s_lim = 1'b0;
  logic s_flr = 1'b0;
  logic s_chg = 1'b0;
  logic attach = 1'b0;
  logic slow = 1'b0;
  logic [2:0] kind = 3'h1;
  logic [2:0] hlim = 3'h0;
  logic vbus, con, pri, sec, nst;
  cpd_pkg::cpd_lim_t lim;
  cpd_pkg::cpd_floor_t flr;
  cpd_pkg::cpd_tmr_t tmr;
  logic fault, host, dsrc, pg_oe, pg_out;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [16:0] lfsr = 17'h13117;
  int ck[8] = '{1, 2, 2, 3, 3, 4, 5, 6};
  int cb[8] = '{1, 1, 0, 1, 0, 1, 1, 1};
  logic [7:0] e;

  initial forever #2.5 mclk_i = ~mclk_i;

  cpd_usb_port_model u_port (.mclk_i(mclk_i), .attach_i(attach), .kind_i(kind), .slow_i(slow),
    .vbus_o(vbus), .contact_o(con), .primary_o(pri), .secondary_o(sec), .nstd_o(nst));

  cpd_top #(.WDOG_CYCLES(WDOG), .DCD_CYCLES(DCD)) u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .limit_select_low_i(sel_lo), .limit_select_high_i(sel_hi),
    .supply_good_i(sup), .vbus_present_i(vbus), .battery_good_i(batt), .lim_pin_short_i(s_lim),
    .floor_pin_short_i(s_flr), .chg_pin_short_i(s_chg), .contact_ok_i(con), .primary_dcp_cdp_i(pri),
    .secondary_hi_i(sec), .nstd_pass_i(nst), .host_lim_i(hlim), .input_limit_o(lim),
    .input_voltage_floor_o(flr), .charge_timer_o(tmr), .charge_fault_o(fault), .host_mode_o(host),
    .dplus_src_o(dsrc), .power_good_oe_o(pg_oe), .power_good_out_o(pg_out));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Packed {limit, timer, port} expected after detection
  function automatic logic [7:0] expect_det(input int k, input int b);
    case (k)
      1, 6: return {cpd_pkg::CPD_LIM_EXT, cpd_pkg::CPD_TMR_6H, cpd_pkg::CPD_PORT_DCP};
      2: return b ? {cpd_pkg::CPD_LIM_1500, cpd_pkg::CPD_TMR_6H, cpd_pkg::CPD_PORT_CDP}
                  : {cpd_pkg::CPD_LIM_100, cpd_pkg::CPD_TMR_45M, cpd_pkg::CPD_PORT_CDP};
      3: return b ? {cpd_pkg::CPD_LIM_HIZ, cpd_pkg::CPD_TMR_NONE, cpd_pkg::CPD_PORT_SDP}
                  : {cpd_pkg::CPD_LIM_100, cpd_pkg::CPD_TMR_45M, cpd_pkg::CPD_PORT_SDP};
      default: return {cpd_pkg::CPD_LIM_500, cpd_pkg::CPD_TMR_6H, cpd_pkg::CPD_PORT_NSTD};
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_i);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    attach <= 1'b0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wait_pg();
    for (int i = 0; i < 300 && pg_oe !== 1'b1; i++) @(posedge mclk_i);
    #1;
    chk(pg_oe, 8'h01);
    chk(pg_out, 8'h00);
  endtask

  task automatic pins();
    logic [1:0] p;
    logic [7:0] el, ef;
    for (int i = 0; i < 9; i++) begin
      lfsr = lfsr_next(lfsr);
      p = (i == 0) ? 2'b00 : lfsr[1:0];
      @(posedge mclk_i);
      {sel_hi, sel_lo} <= p;
      s_lim <= (p == 2'b01) & lfsr[2];
      s_flr <= (p == 2'b01) & lfsr[3];
      repeat (3) @(posedge mclk_i);
      #1;
      case (p)
        2'b00: begin el = cpd_pkg::CPD_LIM_500; ef = cpd_pkg::CPD_FLOOR_436; end
        2'b01: begin
          el = s_lim ? cpd_pkg::CPD_LIM_2000 : cpd_pkg::CPD_LIM_EXT;
          ef = s_flr ? cpd_pkg::CPD_FLOOR_436 : cpd_pkg::CPD_FLOOR_EXT;
        end
        2'b10: begin el = cpd_pkg::CPD_LIM_100; ef = cpd_pkg::CPD_FLOOR_436; end
        default: begin el = cpd_pkg::CPD_LIM_HIZ; ef = cpd_pkg::CPD_FLOOR_NONE; end
      endcase
      chk(lim, el);
      chk(flr, ef);
    end
    s_chg <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(fault, 8'h01);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      e = expect_det(ck[i], cb[i]);
      kind <= 3'(ck[i]);
      batt <= cb[i][0];
      slow <= i[0];
      {sel_hi, sel_lo} <= 2'b10;
      s_lim <= 1'b0;
      s_flr <= 1'b0;
      s_chg <= 1'b0;
      do_reset();
      #1;
      chk(pg_oe, 8'h00);
      attach <= 1'b1;
      wait_pg();
      chk(lim, e[7:5]);
      chk(tmr, e[4:3]);
      rd(cpd_pkg::REG_STATUS);
      chk(rdata, {5'h10, e[2:0]});
      chk(dsrc, 8'(cb[i] == 0));
      if (i == 2) begin
        wr(cpd_pkg::REG_DPLUS, 8'h10);
        repeat (2) @(posedge mclk_i);
        chk(dsrc, 8'h01);
        batt <= 1'b1;
        wr(cpd_pkg::REG_DPLUS, 8'h10);
        repeat (2) @(posedge mclk_i);
        chk(dsrc, 8'h00);
      end
      if (i == 0) pins();
      $display("detect case %0d finished", i);
    end
    kind <= 3'h1;
    do_reset();
    lfsr = lfsr_next(lfsr);
    hlim <= 3'(lfsr % 6);
    wr(cpd_pkg::REG_HOSTCFG, 8'h01);
    repeat (3) @(posedge mclk_i);
    chk(host, 8'h01);
    chk(lim, hlim);
    attach <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rd(cpd_pkg::REG_STATUS);
    chk(rdata & 8'h80, 8'h00);
    wr(cpd_pkg::REG_CTRL, 8'h10);
    rd(cpd_pkg::REG_CTRL);
    chk(rdata, 8'h10);
    attach <= 1'b0;
    repeat (2) @(posedge mclk_i);
    attach <= 1'b1;
    wait_pg();
    rd(cpd_pkg::REG_STATUS);
    chk(rdata & 8'h87, 8'h81);
    rd(cpd_pkg::REG_CTRL);
    chk(rdata, 8'h00);
    rd(8'h20);
    chk(rdata, 8'h00);
    repeat (WDOG + 10) @(posedge mclk_i);
    chk(host, 8'h00);
    chk(lim, cpd_pkg::CPD_LIM_EXT);
    sup <= 1'b0;
    wr(cpd_pkg::REG_HOSTCFG, 8'h00);
    repeat (3) @(posedge mclk_i);
    chk(host, 8'h00);
    chk(pg_oe, 8'h00);
    $display("host mode test finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
